// file: inc/dma_defines.svh
// Constants of the DMA sequencer.
// Assumes inclusion by bare name.
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH
// Register index in a channel window (byte = index * 4)
`define REG_CTRL   3'h0
`define REG_STATE  3'h1
`define REG_SRC    3'h2
`define REG_DST    3'h3
`define REG_COUNT  3'h4
// Control register bit positions
`define CB_START   0
`define CB_EXTREQ  1
`define CB_SRCIO   2
`define CB_DSTIO   3
`define CB_SRCINC  4
`define CB_DSTINC  5
`define CB_TRSZ    7:6
`define CB_PORTSZ  9:8
`define CB_NIE     10
`define CB_ABIE    11
`define CB_GLOBAL  12
`define CTRL_MASK  32'h0000_1fff
// State register bit positions
`define SB_ACT     0
`define SB_NC      1
`define SB_ABC     2
`define SB_CONF    3
`define SB_BES     4
`define SB_BED     5
// Size codes
`define SZ_8       2'h3
`define SZ_16      2'h2
`endif

// file: inc/dma_pkg.sv
// Types shared by the DMA sequencer modules.
// Assumes compilation before interfaces and modules.
package dma_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} eng_state_t;
   typedef logic [1:0] size_code_t;
endpackage : dma_pkg

// file: inc/hold_if.sv
// Carrier between the sequencer and its holding buffer.
// Assumes one clock; buffer side only reacts to load.
`timescale 1ns/10ps
`default_nettype none
interface hold_if;
   logic                load;    // Capture one incoming beat
   logic [1:0]          beat;    // Beat index of incoming data
   dma_pkg::size_code_t inSize;  // Width code of incoming beat
   logic [31:0]         inData;  // Right-justified incoming data
   logic [1:0]          outBeat; // Beat index of outgoing data
   dma_pkg::size_code_t outSize; // Width code of outgoing beat
   logic [31:0]         word;    // Whole buffer contents
   logic [31:0]         outData; // Right-justified outgoing slice
   modport engine (output load, beat, inSize, inData, outBeat, outSize,
                   input word, outData);
   modport buffer (input load, beat, inSize, inData, outBeat, outSize,
                   output word, outData);
endinterface : hold_if
`default_nettype wire

// file: rtl/dma_channel_control.sv
// Four-channel dual-address DMA sequencer with register port.
// Assumes a granting bus that ends beats by busReady
// or busError, with right-justified data.
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"
module dma_channel_control (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdData,
   input  wire logic [3:0]  channelRequestLineN,
   output logic [3:0]       channelAcknowledgeN,
   output logic [3:0]       channelIrq,
   output logic             busReq,
   output logic             busGlobal,
   input  wire logic        busGrant,
   output logic             busValid,
   output logic             busWrite,
   output logic [31:0]      busAddr,
   output dma_pkg::size_code_t busSize,
   output logic [31:0]      busWrData,
   input  wire logic [31:0] busRdData,
   input  wire logic        busReady,
   input  wire logic        busError
);
   import dma_pkg::*;

   // Channel registers
   logic [31:0] channelControlReg  [4];
   logic [31:0] channelStateReg    [4];
   logic [31:0] sourceAddress      [4];
   logic [31:0] destinationAddress [4];
   logic [31:0] byteCounter        [4];
   logic [3:0]  startPend;   // Start written, check next cycle
   logic [3:0]  setupErr;    // Per-channel check result
   logic [3:0]  trig;        // External request captured
   logic [3:0]  reqMeta;     // First synchroniser stage
   logic [3:0]  reqSync;     // Request lines, active high
   logic [3:0]  pend;        // Channel wants service
   logic [3:0]  ackPulse;    // One-cycle acknowledge

   // Engine state
   eng_state_t  state;
   eng_state_t  next_state;
   logic [1:0]  cur;         // Channel in service
   logic [1:0]  beat;        // Beat within the phase
   logic        lastGlobal;  // Kind served last
   logic [1:0]  winSys;      // Best system-kind channel
   logic [1:0]  winGlb;      // Best global-kind channel
   logic        anySys;
   logic        anyGlb;
   logic        pickGlobal;
   logic [1:0]  win;

   // Decoded register access
   logic [1:0]  wrCh;
   logic [2:0]  wrReg;
   logic        wrHit;
   logic        rdHit;

   // Current channel views
   logic [31:0] curCtrl;
   logic        curSrcIo;
   logic        curDstIo;
   size_code_t  curTr;
   size_code_t  curPort;
   logic [2:0]  unitBytes;   // Bytes per transfer unit
   logic [1:0]  portBeats;   // Port beats per unit, minus one
   logic [1:0]  lastBeat;    // Last beat of the current phase
   logic        beatDone;
   logic        phaseEnd;
   logic        unitEnd;
   logic [31:0] cntAfter;
   logic        countZero;
   logic        busErrEv;

   hold_if hb ();

   dma_hold_buffer u_hold (
      .clk_sys (clk_sys),
      .srst    (srst),
      .hb      (hb)
   );

   // One checker per channel
   for (genvar g = 0; g < 4; g++) begin : g_chk
      dma_setup_check u_chk (
         .channelControlReg  (channelControlReg[g]),
         .channelStateReg    (channelStateReg[g]),
         .sourceAddress      (sourceAddress[g]),
         .destinationAddress (destinationAddress[g]),
         .byteCounter        (byteCounter[g]),
         .setupError         (setupErr[g])
      );
   end

   // Channel window of eight words
   assign wrCh  = regAddr[6:5];
   assign wrReg = regAddr[4:2];
   assign wrHit = regWr && !regAddr[7];
   assign rdHit = regRd && !regAddr[7] && (regAddr[4:2] <= `REG_COUNT);

   // Request lines are asynchronous: two flops first
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reqMeta <= 4'h0;
         reqSync <= 4'h0;
      end else begin
         reqMeta <= ~channelRequestLineN;
         reqSync <= reqMeta;
      end
   end

   // Internal mode wants bus while active, external waits
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pend[i] = channelStateReg[i][`SB_ACT] &&
                   (!channelControlReg[i][`CB_EXTREQ] || trig[i]);
      end
   end

   // Latch request until acknowledged
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         trig <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (ackPulse[i]) begin
               trig[i] <= 1'b0;
            end else if (reqSync[i] && channelStateReg[i][`SB_ACT]) begin
               trig[i] <= 1'b1;
            end
         end
      end
   end

   // Fixed priority per kind; lowest index wins
   always_comb begin
      winSys = 2'h0;
      winGlb = 2'h0;
      anySys = 1'b0;
      anyGlb = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (pend[i] && channelControlReg[i][`CB_GLOBAL]) begin
            winGlb = 2'(i);
            anyGlb = 1'b1;
         end
         if (pend[i] && !channelControlReg[i][`CB_GLOBAL]) begin
            winSys = 2'(i);
            anySys = 1'b1;
         end
      end
   end

   // Kinds do not rank, so they alternate
   assign pickGlobal = anyGlb && (!anySys || !lastGlobal);
   assign win        = pickGlobal ? winGlb : winSys;

   // Current channel decode
   assign curCtrl   = channelControlReg[cur];
   assign curSrcIo  = curCtrl[`CB_SRCIO];
   assign curDstIo  = curCtrl[`CB_DSTIO];
   assign curTr     = curCtrl[`CB_TRSZ];
   assign curPort   = curCtrl[`CB_PORTSZ];
   assign unitBytes = (curTr == `SZ_8) ? 3'h1 : (curTr == `SZ_16) ? 3'h2 : 3'h4;
   assign portBeats = (curTr == curPort || !curTr[1] && !curPort[1]) ? 2'h0 :
                      (curTr[1] || curPort == `SZ_16) ? 2'h1 : 2'h3;
   assign lastBeat  = ((state == ST_READ) ? curSrcIo : curDstIo) ? portBeats : 2'h0;
   assign beatDone  = busValid && busReady && !busError;
   assign phaseEnd  = beatDone && (beat == lastBeat);
   assign unitEnd   = phaseEnd && (state == ST_WRITE);
   assign cntAfter  = byteCounter[cur] - {29'h0, unitBytes};
   assign countZero = (cntAfter == 32'h0000_0000);
   assign busErrEv  = busValid && busError;

   // Peripheral beats use port width, memory the unit
   assign busValid  = busGrant && (state != ST_IDLE);
   assign busWrite  = (state == ST_WRITE);
   assign busReq    = (state != ST_IDLE) || (|pend);
   assign busGlobal = (state != ST_IDLE) ? curCtrl[`CB_GLOBAL] : pickGlobal;
   assign busSize   = (busWrite ? curDstIo : curSrcIo) ? curPort : curTr;
   // Peripheral address fixed: beats on low lanes
   assign busAddr   = busWrite ? destinationAddress[cur] : sourceAddress[cur];
   assign busWrData = hb.outData;

   // Holding buffer hookup
   assign hb.load    = beatDone && (state == ST_READ);
   assign hb.beat    = beat;
   assign hb.inSize  = curSrcIo ? curPort : curTr;
   assign hb.inData  = busRdData;
   assign hb.outBeat = beat;
   assign hb.outSize = curDstIo ? curPort : curTr;

   // Acknowledge per peripheral unit or memory count end
   always_comb begin
      ackPulse = 4'h0;
      if (unitEnd && (curSrcIo || curDstIo || countZero)) begin
         ackPulse[cur] = 1'b1;
      end
   end
   assign channelAcknowledgeN = ~ackPulse;

   // Next engine state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if ((|pend) && busGrant) begin
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            if (busErrEv) begin
               next_state = ST_IDLE;
            end else if (phaseEnd) begin
               next_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // Rearbitrate: a lower-index channel may take over
            if (busErrEv || unitEnd) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Engine sequencing registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state      <= ST_IDLE;
         cur        <= 2'h0;
         beat       <= 2'h0;
         lastGlobal <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && next_state == ST_READ) begin
            cur        <= win;
            lastGlobal <= pickGlobal;
         end
         beat <= (phaseEnd || state == ST_IDLE) ? 2'h0 : beat + 2'(beatDone);
      end
   end

   // Control register and start detection
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            channelControlReg[i] <= 32'h0000_0000;
         end
         startPend <= 4'h0;
      end else begin
         startPend <= 4'h0;
         if (wrHit && wrReg == `REG_CTRL) begin
            channelControlReg[wrCh] <= regWrData & `CTRL_MASK;
            startPend[wrCh] <= regWrData[`CB_START];
         end
      end
   end

   // Hardware set beats a software clear in one cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            channelStateReg[i] <= 32'h0000_0000;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            logic [31:0] s;
            s = channelStateReg[i];
            if (wrHit && wrReg == `REG_STATE && wrCh == 2'(i)) begin
               s = s & ~(regWrData & 32'h0000_003e);
            end
            if (startPend[i]) begin
               if (setupErr[i]) begin
                  s[`SB_ABC]  = 1'b1;
                  s[`SB_CONF] = 1'b1;
                  s[`SB_ACT]  = 1'b0;
               end else begin
                  s[`SB_ACT] = 1'b1;
               end
            end
            if (cur == 2'(i) && busErrEv) begin
               s[`SB_ABC] = 1'b1;
               s[`SB_BES] = s[`SB_BES] | (state == ST_READ);
               s[`SB_BED] = s[`SB_BED] | (state == ST_WRITE);
               s[`SB_ACT] = 1'b0;
            end
            if (cur == 2'(i) && unitEnd && countZero) begin
               s[`SB_NC]  = 1'b1;
               s[`SB_ACT] = 1'b0;
            end
            channelStateReg[i] <= s;
         end
      end
   end

   // Engine moves address and count only after a unit, so a
   // setup error leaves them untouched
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            sourceAddress[i]      <= 32'h0000_0000;
            destinationAddress[i] <= 32'h0000_0000;
            byteCounter[i]        <= 32'h0000_0000;
         end
      end else if (unitEnd) begin
         byteCounter[cur] <= cntAfter;
         if (curCtrl[`CB_SRCINC] && !curSrcIo) begin
            sourceAddress[cur] <= sourceAddress[cur] + {29'h0, unitBytes};
         end
         if (curCtrl[`CB_DSTINC] && !curDstIo) begin
            destinationAddress[cur] <= destinationAddress[cur] + {29'h0, unitBytes};
         end
      end else if (wrHit) begin
         case (wrReg)
            `REG_SRC:   sourceAddress[wrCh]      <= regWrData;
            `REG_DST:   destinationAddress[wrCh] <= regWrData;
            `REG_COUNT: byteCounter[wrCh]        <= regWrData;
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk_sys) begin
      if (srst || !rdHit) begin
         regRdData <= 32'h0000_0000;
      end else begin
         case (wrReg)
            `REG_CTRL:  regRdData <= channelControlReg[wrCh];
            `REG_STATE: regRdData <= channelStateReg[wrCh];
            `REG_SRC:   regRdData <= sourceAddress[wrCh];
            `REG_DST:   regRdData <= destinationAddress[wrCh];
            default:    regRdData <= byteCounter[wrCh];
         endcase
      end
   end

   // Interrupt stays up while an enabled flag stays set
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         channelIrq[i] = (channelStateReg[i][`SB_NC] && channelControlReg[i][`CB_NIE]) ||
                         (channelStateReg[i][`SB_ABC] && channelControlReg[i][`CB_ABIE]);
      end
   end
endmodule : dma_channel_control
`default_nettype wire

// file: rtl/dma_hold_buffer.sv
// 32-bit holding buffer that packs and unpacks narrow beats.
// Assumes little-endian lanes, beat 0 lowest.
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"
module dma_hold_buffer (
   input  wire logic clk_sys,
   input  wire logic srst,
   hold_if.buffer    hb
);
   import dma_pkg::*;
   logic [31:0] holdingBuffer; // Buffered transfer unit
   logic [4:0]  inShift;       // Bit offset of incoming beat
   logic [4:0]  outShift;      // Bit offset of outgoing beat
   logic [31:0] inMask;        // Lanes written by incoming beat

   // Beat width times index gives the lane offset
   function automatic logic [4:0] lane_off(input size_code_t sz, input logic [1:0] b);
      lane_off = (sz == `SZ_8) ? {b, 3'h0} : (sz == `SZ_16) ? {b[0], 4'h0} : 5'h00;
   endfunction : lane_off

   assign inShift    = lane_off(hb.inSize, hb.beat);
   assign outShift   = lane_off(hb.outSize, hb.outBeat);
   assign inMask     = ((hb.inSize == `SZ_8) ? 32'h0000_00ff :
                        (hb.inSize == `SZ_16) ? 32'h0000_ffff : 32'hffff_ffff) << inShift;
   assign hb.word    = holdingBuffer;
   assign hb.outData = holdingBuffer >> outShift;

   // Merge the beat, other lanes keep earlier beats
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         holdingBuffer <= 32'h0000_0000;
      end else if (hb.load) begin
         holdingBuffer <= (holdingBuffer & ~inMask) | ((hb.inData << inShift) & inMask);
      end
   end
endmodule : dma_hold_buffer
`default_nettype wire

// file: rtl/dma_setup_check.sv
// Combinational configuration check for one channel.
// Assumes the channel's live register values.
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"
module dma_setup_check (
   input  wire logic [31:0] channelControlReg,
   input  wire logic [31:0] channelStateReg,
   input  wire logic [31:0] sourceAddress,
   input  wire logic [31:0] destinationAddress,
   input  wire logic [31:0] byteCounter,
   output logic             setupError
);
   import dma_pkg::*;
   size_code_t  trSize;   // Transfer size code
   size_code_t  portSize; // Peripheral port size code
   logic [31:0] alignMsk; // Low bits that must be zero
   logic        sizeBad;  // Port wider than transfer

   assign trSize   = channelControlReg[`CB_TRSZ];
   assign portSize = channelControlReg[`CB_PORTSZ];
   assign alignMsk = (trSize == `SZ_8) ? 32'h0000_0000 :
                     (trSize == `SZ_16) ? 32'h0000_0001 : 32'h0000_0003;
   // A narrower transfer forbids any wider port
   assign sizeBad  = ((trSize == `SZ_16) && !portSize[1]) ||
                     ((trSize == `SZ_8) && (portSize != `SZ_8));
   assign setupError =
      (channelControlReg[`CB_SRCIO] && channelControlReg[`CB_DSTIO]) ||
      channelStateReg[`SB_NC] || channelStateReg[`SB_ABC] ||
      ((byteCounter & alignMsk) != 32'h0000_0000) ||
      (((sourceAddress | destinationAddress) & alignMsk) != 32'h0000_0000) ||
      sizeBad ||
      (byteCounter == 32'h0000_0000);
endmodule : dma_setup_check
`default_nettype wire

// file: sim/dma_bus_model.sv
// Bus model with a small memory.
// Assumes 64 words on address bits 7:2.
`timescale 1ns/10ps
`default_nettype none
module dma_bus_model (
   input  wire logic                clk_sys,
   input  wire logic                srst,
   input  wire logic                busReq,
   input  wire logic                busValid,
   input  wire logic                busWrite,
   input  wire logic [31:0]         busAddr,
   input  wire dma_pkg::size_code_t busSize,
   input  wire logic [31:0]         busWrData,
   input  wire logic                slow,
   input  wire logic [31:0]         errAddr,
   output logic                     busGrant,
   output logic [31:0]              busRdData,
   output logic                     busReady,
   output logic                     busError
);
   import dma_pkg::*;
   logic [31:0] mem [64];  // Word store
   logic        waited;    // Wait state served
   logic [31:0] noise;     // Toggles so stale data never looks valid
   wire [4:0]  sh   = {busAddr[1:0], 3'h0};                      // Lane shift
   wire [31:0] msk  = busSize[1] ? (busSize[0] ? 32'hff : 32'hffff) : 32'hffff_ffff;
   wire        done = busValid && (waited || !slow);             // Beat ends now
   wire        hit  = (busAddr == errAddr);                      // Faulting place
   assign busGrant  = busReq;
   assign busReady  = done && !hit;
   assign busError  = done && hit;
   // Read data stand only in the ending cycle
   assign busRdData = (busReady && !busWrite) ? ((mem[busAddr[7:2]] >> sh) & msk) : noise;
   initial for (int i = 0; i < 64; i++) mem[i] = 32'h0403_0201 + 32'h1010_1010 * i;
   // Beats end and writes land on rising edges
   always @(posedge clk_sys) begin
      noise  <= srst ? 32'h5a5a_a5a5 : ~noise;
      waited <= busValid && !done && !srst;
      if (busReady && busWrite) begin
         mem[busAddr[7:2]] <= (mem[busAddr[7:2]] & ~(msk << sh)) | ((busWrData & msk) << sh);
      end
   end
endmodule : dma_bus_model
`default_nettype wire

// file: sim/dma_chan_chk.sv
// Port checker of the DMA sequencer.
// Assumes one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dma_chan_chk (
   input wire logic                clk_sys,
   input wire logic                srst,
   input wire logic                regWr,
   input wire logic [3:0]          channelAcknowledgeN,
   input wire logic [3:0]          channelIrq,
   input wire logic                busReq,
   input wire logic                busGrant,
   input wire logic                busValid,
   input wire logic                busWrite,
   input wire logic [31:0]         busAddr,
   input wire dma_pkg::size_code_t busSize,
   input wire logic                busReady,
   input wire logic                busError
);
   import dma_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire ackAny  = (channelAcknowledgeN != 4'hf);         // Some channel acknowledges
   wire beatEnd = busValid && (busReady || busError);    // Beat finishes now
   // Bus side quiet after reset
   property p_reset;
      disable iff (1'b0) srst |=> !busReq && !busValid && !ackAny && channelIrq == 4'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("engine active after reset");
   property p_hold;
      busValid && !beatEnd |=> busValid && $stable(busAddr) && $stable(busWrite)
         && $stable(busSize);
   endproperty
   a_hold: assert property (p_hold) else $error("bus cycle changed early");
   property p_start;
      busReq && busGrant && !busValid |-> ##[1:2] busValid;
   endproperty
   a_start: assert property (p_start) else $error("granted request idle");
   // Beats of one phase share an address
   property p_same_addr;
      busValid && busReady && !busError ##1 busValid && busWrite == $past(busWrite)
         |-> busAddr == $past(busAddr);
   endproperty
   a_same_addr: assert property (p_same_addr) else $error("peripheral address moved");
   property p_ack_pulse;
      ackAny |=> !ackAny;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge too long");
   property p_ack_cause;
      ackAny |-> busValid && busWrite && busReady;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge off write");
   property p_ack_one;
      $onehot0(~channelAcknowledgeN);
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("two acknowledges");
   property p_err_stop;
      busValid && busError |=> !busValid;
   endproperty
   a_err_stop: assert property (p_err_stop) else $error("bus cycle after error");
   property p_read_first;
      $rose(busValid) |-> !busWrite;
   endproperty
   a_read_first: assert property (p_read_first) else $error("unit began with write");
   // Interrupts drop only after a register write
   property p_irq_sticky;
      (|($past(channelIrq) & ~channelIrq)) |-> $past(regWr);
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped");
   c_err: cover property (busValid && busError);
   c_ack: cover property (ackAny);
   c_irq: cover property (|channelIrq);
endmodule : dma_chan_chk
bind dma_channel_control dma_chan_chk CHK (.clk_sys, .srst, .regWr, .channelAcknowledgeN,
   .channelIrq, .busReq, .busGrant, .busValid, .busWrite, .busAddr, .busSize, .busReady,
   .busError);
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the DMA sequencer.
// Assumes the bus model and bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dma_pkg::*;
   typedef struct {logic [31:0] ctrl, src, cnt, st; logic irq;} row_t;
   logic        clk_sys = 1'b0;             // 200 MHz clock
   logic        srst = 1'b1;                // Synchronous reset
   logic [7:0]  regAddr = 8'h00;            // Register port
   logic [31:0] regWrData = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdData;
   logic [3:0]  channelRequestLineN = 4'hf; // Requests idle high
   logic [3:0]  channelAcknowledgeN, channelIrq;
   logic        busReq, busGlobal, busGrant, busValid, busWrite, busReady, busError;
   logic [31:0] busAddr, busWrData, busRdData;
   size_code_t  busSize;
   logic        slow = 1'b0;                // One wait state per beat
   logic [31:0] errAddr = 32'hffff_ffff;    // Address that faults
   logic [31:0] s;                          // Last register read
   int          n_fail = 0;
   int          samples_checked = 0;
   // Cases: control, source, count, state, irq
   row_t rows [7] = '{
      '{32'h431, 32'h0, 32'h8, 32'h2, 1'b1},   // Word copy, normal irq on
      '{32'h80d, 32'h0, 32'h4, 32'hc, 1'b1},   // Both sides peripheral
      '{32'h2b1, 32'h0, 32'h3, 32'hc, 1'b0},   // Count off the size
      '{32'h031, 32'h2, 32'h4, 32'hc, 1'b0},   // Misaligned source
      '{32'h087, 32'h0, 32'h2, 32'hc, 1'b0},   // Port wider than size
      '{32'h031, 32'h0, 32'h0, 32'hc, 1'b0},   // Empty counter
      '{32'h3f1, 32'h1, 32'h3, 32'h2, 1'b0}};  // Byte copy
   dma_channel_control DUT (.clk_sys, .srst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .channelRequestLineN, .channelAcknowledgeN, .channelIrq, .busReq,
      .busGlobal, .busGrant, .busValid, .busWrite, .busAddr, .busSize, .busWrData,
      .busRdData, .busReady, .busError);
   dma_bus_model MEM (.clk_sys, .srst, .busReq, .busValid, .busWrite, .busAddr, .busSize,
      .busWrData, .slow, .errAddr, .busGrant, .busRdData, .busReady, .busError);
   always #2.5 clk_sys = ~clk_sys;
   task automatic finish_test();
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   // Strobe then one idle edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys) regWr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys) regRd <= 1'b0;
      @(posedge clk_sys) d = regRdData;
   endtask : rd
   // Poll state for a completion flag
   task automatic waitDone(input logic [7:0] b, output logic [31:0] d);
      for (int i = 0; i < 100; i++) begin
         rd(b + 8'h04, d);
         if (d[2:1] !== 2'b00) return;
      end
      n_fail++;
      finish_test();
   endtask : waitDone
   // Wait for ack 0 or a bus cycle at an address
   task automatic waitBus(input logic ack, input logic [31:0] a);
      for (int i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         if (ack && channelAcknowledgeN[0] === 1'b0) return;
         if (!ack && busValid === 1'b1 && busAddr === a) return;
      end
      n_fail++;
      finish_test();
   endtask : waitBus
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      cmp("ack", 32'hf, {28'h0, channelAcknowledgeN});
      rd(8'h04, s);
      cmp("state", 32'h0, s);
      wr(8'h94, 32'hffff_ffff);
      rd(8'h94, s);
      cmp("unmapped", 32'h0, s);
      foreach (rows[i]) begin
         wr(8'h08, rows[i].src);
         wr(8'h0c, 32'h40);
         wr(8'h10, rows[i].cnt);
         wr(8'h00, rows[i].ctrl);
         waitDone(8'h00, s);
         cmp("state", rows[i].st, s);
         cmp("irq", {31'h0, rows[i].irq}, {31'h0, channelIrq[0]});
         rd(8'h10, s);
         cmp("count", rows[i].st[3] ? rows[i].cnt : 32'h0, s);
         if (i == 0) begin
            cmp("word0", 32'h0403_0201, MEM.mem[16]);
            cmp("word1", 32'h1413_1211, MEM.mem[17]);
         end
         wr(8'h04, 32'h3e);
      end
      // Restart with done still set
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h40);
      wr(8'h10, 32'h4);
      wr(8'h00, 32'h031);
      waitDone(8'h00, s);
      wr(8'h00, 32'h031);
      repeat (2) @(posedge clk_sys);
      rd(8'h04, s);
      cmp("restart", 32'he, s);
      wr(8'h04, 32'h3e);
      // Source then destination fault, slow bus
      slow <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         errAddr <= j ? 32'h40 : 32'h0;
         wr(8'h08, 32'h0);
         wr(8'h0c, 32'h40);
         wr(8'h10, 32'h4);
         wr(8'h00, 32'h031);
         waitDone(8'h00, s);
         cmp("bus error", j ? 32'h24 : 32'h14, s);
         wr(8'h04, 32'h3e);
      end
      slow <= 1'b0;
      errAddr <= 32'hffff_ffff;
      // Byte peripheral to memory
      wr(8'h08, 32'h20);
      wr(8'h10, 32'h2);
      wr(8'h00, 32'h3e7);
      repeat (10) @(posedge clk_sys);
      cmp("idle request", 32'h0, {31'h0, busReq});
      rd(8'h04, s);
      cmp("ready", 32'h1, s);
      repeat (2) begin
         channelRequestLineN[0] <= 1'b0; // Held four clocks, then released
         repeat (4) @(posedge clk_sys);
         channelRequestLineN[0] <= 1'b1;
         waitBus(1'b1, 32'h0);
      end
      waitDone(8'h00, s);
      cmp("periph done", 32'h2, s);
      cmp("periph data", 32'h8181, MEM.mem[16] & 32'hffff);
      wr(8'h04, 32'h3e);
      // Channel 0 preempts channel 1 at a unit edge
      slow <= 1'b1;
      wr(8'h28, 32'h0);
      wr(8'h2c, 32'h80);
      wr(8'h30, 32'h8);
      wr(8'h20, 32'h033);
      wr(8'h08, 32'h10);
      wr(8'h0c, 32'h40);
      wr(8'h10, 32'h4);
      wr(8'h00, 32'h033);
      channelRequestLineN[1] <= 1'b0;
      waitBus(1'b0, 32'h0);
      channelRequestLineN[0] <= 1'b0;
      waitBus(1'b0, 32'h10);
      rd(8'h30, s);
      cmp("suspended count", 32'h4, s);
      waitDone(8'h20, s);
      cmp("resumed", 32'h2, s);
      channelRequestLineN <= 4'hf;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
